// ### stream_entry_decode.sv
//
// Behaviour
// - valid bit clear means entry invalid
// - forbidden field combinations act as invalid
// - stage-two off ignores stage-two fields
// - stage-one off ignores stage-one fields
// - decode config: abort, bypass, s1, s2, both
// - stage one absent forbids stage-one translate
// - stage two absent or secure forbids s2
// - bypass denies ats, flags translated traffic
// - config zero: ats gets UR, no event
// - linear table indexed by low substream bits
// - 4KB leaves, 64 descriptors, bits [5:0]
// - 64KB leaves, 1024 descriptors, bits [9:0]
// - reserved format acts as linear
// - no two-level support forbids two-level format
// - stage one off rejects substream transactions
// - zero substream width rejects substream ids
// - zero count: one descriptor, reject substreams
// - substream outside span aborts with event
// - count above width is forbidden
// - descriptor address from pointer, ipa if s2
// - default terminate aborts substream-less traffic
// - default bypass skips stage one
// - default zero uses descriptor zero
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module stream_entry_decode #(
  parameter int SSID_W = 20
) (
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               req_valid,
  input  wire ste_pkg::kind_e     req_kind,
  input  wire logic               req_has_ssid,
  input  wire logic [SSID_W-1:0]  req_ssid,
  input  wire logic               req_addr_over_ias,
  output logic                    rsp_valid,
  output ste_pkg::outcome_e       rsp_outcome,
  output ste_pkg::event_e         rsp_event,
  output logic                    rsp_stage1,
  output logic                    rsp_stage2,
  output logic                    rsp_cd_fetch,
  output logic                    rsp_cd_ipa,
  output logic                    rsp_cd_two_level,
  output logic      [51:0]        rsp_cd_addr,
  output logic      [15:0]        rsp_leaf_off
);

  logic        rst_n;
  logic [31:0] word0_r, word1_r, word2_r, caps_r;
  logic [95:0] entry;
  logic        v, s1p, s2p, two_level_cd_support, chk, secure, ss_on;
  logic [2:0]  cfg;
  logic [1:0]  fmt, dss;
  logic [4:0]  cdmax, ssw;
  logic        bad_s1, bad_s2, bad_fmt, bad_max, illegal;
  logic        ssid_out;
  logic [SSID_W-1:0] idx_ssid;
  logic [51:0] loc_addr;
  logic        loc_two;
  logic [15:0] loc_leaf;
  logic        apb_wr;
  logic [31:0] rd_data;
  logic        rd_err;
  ste_pkg::outcome_e out_nxt;
  ste_pkg::event_e   ev_nxt;
  logic        st1_nxt, st2_nxt;

  // ==========================================================
  // reset release
  reset_release u_rst (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .rst_n_sync (rst_n)
  );

  // ==========================================================
  // apb slave: one access cycle, read data registered in setup
  assign apb_wr = psel && penable && pready && pwrite;

  // entry words and capability bits written only at access edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      word0_r <= 32'h0;
      word1_r <= 32'h0;
      word2_r <= 32'h0;
      caps_r  <= ste_pkg::CAP_RST;
    end else if (apb_wr) begin
      case (paddr)
        ste_pkg::OFF_WORD0: word0_r <= pwdata;
        ste_pkg::OFF_WORD1: word1_r <= pwdata;
        ste_pkg::OFF_WORD2: word2_r <= pwdata;
        ste_pkg::OFF_CAPS:  caps_r  <= pwdata;
        default: ;
      endcase
    end
  end

  // read mux; status is read-only and a write to it is dropped
  always_comb begin
    rd_err  = 1'b0;
    rd_data = 32'h0;
    case (paddr)
      ste_pkg::OFF_WORD0: rd_data = word0_r;
      ste_pkg::OFF_WORD1: rd_data = word1_r;
      ste_pkg::OFF_WORD2: rd_data = word2_r;
      ste_pkg::OFF_CAPS:  rd_data = caps_r;
      ste_pkg::OFF_STAT:  rd_data = {25'h0, rsp_event, rsp_outcome,
                                     !illegal, rsp_valid};
      default:            rd_err  = 1'b1;
    endcase
  end

  // pready rises in setup so no wait states; error only on unmapped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && rd_err;
      prdata  <= (psel && !penable && !pwrite) ? rd_data : 32'h0;
    end
  end

  // ==========================================================
  // entry fields and validity
  always_comb begin
    entry   = {word2_r, word1_r, word0_r};
    v       = entry[ste_pkg::V_BIT];
    cfg     = entry[ste_pkg::CFG_LO +: 3];
    fmt     = entry[ste_pkg::FMT_LO +: 2];
    cdmax   = entry[ste_pkg::MAX_LO +: 5];
    dss     = entry[ste_pkg::DSS_LO +: 2];
    s1p     = caps_r[ste_pkg::CAP_S1P];
    s2p     = caps_r[ste_pkg::CAP_S2P];
    two_level_cd_support    = caps_r[ste_pkg::CAP_TWO_LEVEL_CD_SUPPORT];
    chk     = caps_r[ste_pkg::CAP_CHK];
    secure  = caps_r[ste_pkg::CAP_SEC];
    ssw     = caps_r[ste_pkg::CAP_SSW_LO +: 5];
    // stage-one fields only count while stage one translates
    ss_on   = cfg[2] && cfg[0] && cdmax != 5'h0 && ssw != 5'h0;
    bad_s1  = cfg[2] && cfg[0] && !s1p;
    bad_s2  = cfg[2] && cfg[1] && (!s2p || secure);
    bad_fmt = ss_on && !two_level_cd_support && (fmt == ste_pkg::FMT_4K ||
                                 fmt == ste_pkg::FMT_64K);
    bad_max = cfg[2] && cfg[0] && cdmax > ssw;
    // any forbidden combination collapses onto invalid
    illegal = !v || bad_s1 || bad_s2 || bad_fmt || bad_max;
    ssid_out = (req_ssid >> cdmax) != '0;
    idx_ssid = (req_has_ssid) ? req_ssid : '0;
  end

  // descriptor locator; stage-two fields are never decoded
  cd_locate #(
    .SSID_W (SSID_W)
  ) u_loc (
    .base      (entry[ste_pkg::PTR_HI:ste_pkg::PTR_LO]),
    .fmt       (fmt),
    .cdmax     (cdmax),
    .ssid      (idx_ssid),
    .addr      (loc_addr),
    .two_level (loc_two),
    .leaf_off  (loc_leaf)
  );

  // ==========================================================
  // outcome decision, highest priority first
  always_comb begin
    out_nxt = ste_pkg::OUT_ABORT;
    ev_nxt  = ste_pkg::EV_NONE;
    st1_nxt = 1'b0;
    st2_nxt = 1'b0;
    if (illegal) begin
      // ats gets UR, checked translated aborts quietly
      if (req_kind == ste_pkg::KIND_ATS_REQ) begin
        out_nxt = ste_pkg::OUT_UR;
      end else if (!(req_kind == ste_pkg::KIND_TRANSL && chk)) begin
        ev_nxt = ste_pkg::EV_BAD_ENTRY;
      end
    end else if (!cfg[2]) begin
      // abort without event; ats completes UR
      if (req_kind == ste_pkg::KIND_ATS_REQ) begin
        out_nxt = ste_pkg::OUT_UR;
      end
    end else if (cfg == ste_pkg::CFG_BYPASS &&
                 req_kind == ste_pkg::KIND_ATS_REQ) begin
      ev_nxt = ste_pkg::EV_BAD_ATS_REQ;
    end else if (cfg == ste_pkg::CFG_BYPASS && chk &&
                 req_kind == ste_pkg::KIND_TRANSL) begin
      ev_nxt = ste_pkg::EV_TRANSL_FORBIDDEN;
    end else if (!cfg[0]) begin
      if (req_has_ssid) begin
        ev_nxt = ste_pkg::EV_BAD_SUBSTREAM;
      end else begin
        out_nxt = ste_pkg::OUT_PASS;
        st2_nxt = cfg[1];
      end
    end else if (req_has_ssid &&
                 (ssw == 5'h0 || cdmax == 5'h0)) begin
      ev_nxt = ste_pkg::EV_BAD_SUBSTREAM;
    end else if (req_has_ssid && ssid_out) begin
      ev_nxt = ste_pkg::EV_BAD_SUBSTREAM;
    end else if (req_has_ssid && dss == ste_pkg::DSS_SS0 &&
                 req_ssid == '0) begin
      ev_nxt = ste_pkg::EV_STREAM_DISABLED;
    end else if (req_has_ssid || !ss_on ||
                 dss == ste_pkg::DSS_SS0) begin
      out_nxt = ste_pkg::OUT_PASS;
      st1_nxt = 1'b1;
      st2_nxt = cfg[1];
    end else if (dss == ste_pkg::DSS_BYP) begin
      // stage one skipped, no descriptor fetched
      if (req_addr_over_ias) begin
        ev_nxt = ste_pkg::EV_S1_ADDR_SIZE;
      end else begin
        out_nxt = ste_pkg::OUT_PASS;
        st2_nxt = cfg[1];
      end
    end else if (req_kind != ste_pkg::KIND_ATS_REQ) begin
      ev_nxt = ste_pkg::EV_STREAM_DISABLED;
    end
  end

  // ==========================================================
  // one registered answer per request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid   <= 1'b0;
      rsp_outcome <= ste_pkg::OUT_ABORT;
      rsp_event   <= ste_pkg::EV_NONE;
      rsp_stage1  <= 1'b0;
      rsp_stage2  <= 1'b0;
    end else begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        rsp_outcome <= out_nxt;
        rsp_event   <= ev_nxt;
        rsp_stage1  <= st1_nxt;
        rsp_stage2  <= st2_nxt;
      end
    end
  end

  // descriptor location is only meaningful when stage one runs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_cd_fetch     <= 1'b0;
      rsp_cd_ipa       <= 1'b0;
      rsp_cd_two_level <= 1'b0;
      rsp_cd_addr      <= 52'h0;
      rsp_leaf_off     <= 16'h0;
    end else if (req_valid) begin
      rsp_cd_fetch     <= st1_nxt && out_nxt == ste_pkg::OUT_PASS;
      rsp_cd_ipa       <= cfg[1];
      rsp_cd_two_level <= loc_two && ss_on;
      rsp_cd_addr      <= loc_addr;
      rsp_leaf_off     <= loc_leaf;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_abort(ste_pkg::event_e e);
    rsp_valid && rsp_outcome == ste_pkg::OUT_ABORT && rsp_event == e;
  endsequence

  sequence s_plain_req;
    req_valid && req_kind == ste_pkg::KIND_PLAIN;
  endsequence

  property p_invalid;
    s_plain_req and !v |=> s_abort(ste_pkg::EV_BAD_ENTRY);
  endproperty
  a_invalid: assert property (p_invalid)
    else $error("invalid entry not aborted with event");

  property p_no_s1;
    s_plain_req and (cfg[2] && cfg[0] && !s1p)
      |=> s_abort(ste_pkg::EV_BAD_ENTRY);
  endproperty
  a_no_s1: assert property (p_no_s1)
    else $error("stage one absent not forbidden");

  property p_sec_s2;
    s_plain_req and (cfg[2] && cfg[1] && secure)
      |=> s_abort(ste_pkg::EV_BAD_ENTRY);
  endproperty
  a_sec_s2: assert property (p_sec_s2)
    else $error("secure stage two not forbidden");

  property p_cfg_abort;
    s_plain_req and (!illegal && !cfg[2])
      |=> s_abort(ste_pkg::EV_NONE);
  endproperty
  a_cfg_abort: assert property (p_cfg_abort)
    else $error("config abort not quiet");

  property p_ats_ur;
    req_valid && req_kind == ste_pkg::KIND_ATS_REQ && !illegal &&
      !cfg[2] |=> rsp_outcome == ste_pkg::OUT_UR &&
      rsp_event == ste_pkg::EV_NONE;
  endproperty
  a_ats_ur: assert property (p_ats_ur)
    else $error("ats request not UR");

  property p_ats_bypass;
    req_valid && req_kind == ste_pkg::KIND_ATS_REQ && !illegal &&
      cfg == ste_pkg::CFG_BYPASS
      |=> s_abort(ste_pkg::EV_BAD_ATS_REQ);
  endproperty
  a_ats_bypass: assert property (p_ats_bypass)
    else $error("bypass ats request not denied");

  property p_s1off_ssid;
    req_valid && req_has_ssid && !illegal && cfg[2] && !cfg[0] &&
      req_kind == ste_pkg::KIND_PLAIN
      |=> s_abort(ste_pkg::EV_BAD_SUBSTREAM) ##1 !rsp_stage1;
  endproperty
  a_s1off_ssid: assert property (p_s1off_ssid)
    else $error("substream passed with stage one off");

  property p_range;
    s_plain_req and (req_has_ssid && !illegal && ss_on && ssid_out)
      |=> s_abort(ste_pkg::EV_BAD_SUBSTREAM);
  endproperty
  a_range: assert property (p_range)
    else $error("out of span substream not aborted");

  property p_dss_term;
    s_plain_req and (!req_has_ssid && !illegal && ss_on &&
      dss == ste_pkg::DSS_TERM)
      |=> s_abort(ste_pkg::EV_STREAM_DISABLED);
  endproperty
  a_dss_term: assert property (p_dss_term)
    else $error("default terminate not applied");

  property p_answer;
    req_valid |=> rsp_valid ##1 (rsp_valid == $past(req_valid));
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered next cycle");

endmodule

`default_nettype wire

// ### ste_pkg.sv
package ste_pkg;

  // ==========================================================
  // register map, byte addresses on the apb port
  localparam logic [11:0] OFF_WORD0 = 12'h000;
  localparam logic [11:0] OFF_WORD1 = 12'h004;
  localparam logic [11:0] OFF_WORD2 = 12'h008;
  localparam logic [11:0] OFF_CAPS  = 12'h00c;
  localparam logic [11:0] OFF_STAT  = 12'h010;

  // ==========================================================
  // stream table entry field positions (bit index in the entry)
  localparam int V_BIT   = 0;
  localparam int CFG_LO  = 1;
  localparam int FMT_LO  = 4;
  localparam int PTR_LO  = 6;
  localparam int PTR_HI  = 51;
  localparam int MAX_LO  = 59;
  localparam int DSS_LO  = 64;

  // ==========================================================
  // capability / control register fields and reset value
  localparam int CAP_S1P    = 0;
  localparam int CAP_S2P    = 1;
  localparam int CAP_TWO_LEVEL_CD_SUPPORT   = 2;
  localparam int CAP_CHK    = 3;
  localparam int CAP_SEC    = 4;
  localparam int CAP_SSW_LO = 5;
  localparam logic [31:0] CAP_RST = 32'h0000_0287;

  // ==========================================================
  // encodings
  localparam logic [2:0] CFG_BYPASS = 3'h4;
  localparam logic [1:0] FMT_LINEAR = 2'h0;
  localparam logic [1:0] FMT_4K     = 2'h1;
  localparam logic [1:0] FMT_64K    = 2'h2;
  localparam logic [1:0] DSS_TERM   = 2'h0;
  localparam logic [1:0] DSS_BYP    = 2'h1;
  localparam logic [1:0] DSS_SS0    = 2'h2;

  // ==========================================================
  // descriptor table geometry and reset synchroniser depth
  localparam int CD_LOG2     = 6;
  localparam int L1E_LOG2    = 3;
  localparam int LEAF4K_LOG  = 6;
  localparam int LEAF64K_LOG = 10;
  localparam int RST_STAGES  = 2;

  typedef enum logic [1:0] {
    KIND_PLAIN, KIND_ATS_REQ, KIND_TRANSL
  } kind_e;

  typedef enum logic [1:0] {
    OUT_PASS, OUT_ABORT, OUT_UR
  } outcome_e;

  typedef enum logic [2:0] {
    EV_NONE, EV_BAD_ENTRY, EV_BAD_SUBSTREAM, EV_STREAM_DISABLED,
    EV_BAD_ATS_REQ, EV_TRANSL_FORBIDDEN, EV_S1_ADDR_SIZE
  } event_e;

endpackage

// ### reset_release.sv
`timescale 1ns/1ps
`default_nettype none

module reset_release (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  output logic      rst_n_sync
);

  logic [ste_pkg::RST_STAGES-1:0] stage_r;

  // ==========================================================
  // assert at once, release after two clean edges
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_r <= '0;
    end else begin
      stage_r <= {stage_r[ste_pkg::RST_STAGES-2:0], 1'b1};
    end
  end

  assign rst_n_sync = stage_r[ste_pkg::RST_STAGES-1];

endmodule

`default_nettype wire

// ### cd_locate.sv
`timescale 1ns/1ps
`default_nettype none

module cd_locate #(
  parameter int SSID_W = 20
) (
  input  wire logic [51:6]       base,
  input  wire logic [1:0]        fmt,
  input  wire logic [4:0]        cdmax,
  input  wire logic [SSID_W-1:0] ssid,
  output logic      [51:0]       addr,
  output logic                   two_level,
  output logic      [15:0]       leaf_off
);

  // mask of the n low address bits; n never exceeds 63
  function automatic logic [63:0] low_mask(input logic [6:0] n);
    low_mask = (64'h1 << n) - 64'h1;
  endfunction

  logic [63:0] base64;
  logic [63:0] idx64;
  logic [63:0] sum64;
  logic [6:0]  align;

  // ==========================================================
  // first fetch address: linear slot or level-one pointer slot
  always_comb begin
    base64    = {12'h0, base, 6'h0};
    idx64     = {{(64-SSID_W){1'b0}}, ssid};
    two_level = 1'b0;
    leaf_off  = 16'h0;
    align     = 7'(cdmax) + 7'(ste_pkg::CD_LOG2);
    sum64     = (base64 & ~low_mask(align))
              | (idx64 << ste_pkg::CD_LOG2);
    if (cdmax == 5'h0) begin
      sum64 = base64;
    end else if (fmt == ste_pkg::FMT_4K) begin
      two_level = 1'b1;
      // leaf pointer low 12 bits are dropped by using only this offset
      leaf_off  = 16'({ssid[ste_pkg::LEAF4K_LOG-1:0], 6'h0});
      align     = (cdmax > 5'd9) ? 7'(cdmax) - 7'd3 : 7'd6;
      idx64     = (cdmax > 5'd6) ? idx64 >> ste_pkg::LEAF4K_LOG : 64'h0;
      sum64     = (base64 & ~low_mask(align))
                | (idx64 << ste_pkg::L1E_LOG2);
    end else if (fmt == ste_pkg::FMT_64K) begin
      two_level = 1'b1;
      leaf_off  = {ssid[ste_pkg::LEAF64K_LOG-1:0], 6'h0};
      align     = (cdmax > 5'd13) ? 7'(cdmax) - 7'd7 : 7'd6;
      idx64     = (cdmax > 5'd10) ? idx64 >> ste_pkg::LEAF64K_LOG : 64'h0;
      sum64     = (base64 & ~low_mask(align))
                | (idx64 << ste_pkg::L1E_LOG2);
    end
    // the reserved format falls through to the linear layout
    addr = sum64[51:0];
  end

endmodule

`default_nettype wire

// ### client_master.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// client bus master: one transaction per call of issue
module client_master #(
  parameter int SSID_W = 20
) (
  input  wire logic         sys_clk,
  output logic              req_valid,
  output ste_pkg::kind_e    req_kind,
  output logic              req_has_ssid,
  output logic [SSID_W-1:0] req_ssid,
  output logic              req_addr_over_ias
);
  // idle values at time zero
  initial begin
    req_valid = 1'b0;
    req_kind = ste_pkg::KIND_PLAIN;
    req_has_ssid = 1'b0;
    req_ssid = '0;
    req_addr_over_ias = 1'b0;
  end

  // one-cycle request; then qualifiers invert so stale use shows up
  task automatic issue(input ste_pkg::kind_e k, input logic hs,
                       input logic [SSID_W-1:0] ss, input logic ov);
    req_valid <= 1'b1;
    req_kind <= k;
    req_has_ssid <= hs;
    req_ssid <= ss;
    req_addr_over_ias <= ov;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    req_kind <= ste_pkg::kind_e'(~k);
    req_has_ssid <= ~hs;
    req_ssid <= ~ss;
    req_addr_over_ias <= ~ov;
  endtask
endmodule

`default_nettype wire

// ### stream_entry_decode_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module stream_entry_decode_tb_top;
  localparam int SSID_W = 20;
  localparam logic [45:0] PTR = 46'h2aaa_aaaa_aaab;

  typedef struct packed {
    ste_pkg::outcome_e o;
    ste_pkg::event_e   e;
    logic              s1;
    logic              s2;
  } exp_s;

  // ==========================================================
  // signals
  logic              sys_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              req_valid;
  ste_pkg::kind_e    req_kind;
  logic              req_has_ssid;
  logic [SSID_W-1:0] req_ssid;
  logic              req_addr_over_ias;
  logic              rsp_valid;
  ste_pkg::outcome_e rsp_outcome;
  ste_pkg::event_e   rsp_event;
  logic              rsp_stage1;
  logic              rsp_stage2;
  logic              rsp_cd_fetch;
  logic              rsp_cd_ipa;
  logic              rsp_cd_two_level;
  logic [51:0]       rsp_cd_addr;
  logic [15:0]       rsp_leaf_off;
  int                n_mismatch = 0;
  int                n_checks = 0;
  int                cyc = 0;

  always #2 sys_clk = ~sys_clk;

  stream_entry_decode #(.SSID_W(SSID_W)) DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
    .req_kind(req_kind), .req_has_ssid(req_has_ssid),
    .req_ssid(req_ssid), .req_addr_over_ias(req_addr_over_ias),
    .rsp_valid(rsp_valid), .rsp_outcome(rsp_outcome),
    .rsp_event(rsp_event), .rsp_stage1(rsp_stage1),
    .rsp_stage2(rsp_stage2), .rsp_cd_fetch(rsp_cd_fetch),
    .rsp_cd_ipa(rsp_cd_ipa), .rsp_cd_two_level(rsp_cd_two_level),
    .rsp_cd_addr(rsp_cd_addr), .rsp_leaf_off(rsp_leaf_off));

  client_master #(.SSID_W(SSID_W)) cli (
    .sys_clk(sys_clk), .req_valid(req_valid), .req_kind(req_kind),
    .req_has_ssid(req_has_ssid), .req_ssid(req_ssid),
    .req_addr_over_ias(req_addr_over_ias));

  // ==========================================================
  // closing report and hang guard (run needs about 3700 cycles)
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [51:0] exp,
                       input logic [51:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // ==========================================================
  // apb master: request held until pready is sampled high, giving up after 20 cycles
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    err = pslverr;
    check("pready", 52'h1, 52'(pready));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic load(input logic [95:0] ent, input logic [31:0] cap);
    logic [31:0] q;
    logic        e;
    apb(1'b1, ste_pkg::OFF_WORD0, ent[31:0], q, e);
    apb(1'b1, ste_pkg::OFF_WORD1, ent[63:32], q, e);
    apb(1'b1, ste_pkg::OFF_WORD2, ent[95:64], q, e);
    apb(1'b1, ste_pkg::OFF_CAPS, cap, q, e);
  endtask

  // ==========================================================
  // reference decision for one transaction
  function automatic exp_s predict(input logic [95:0] ent,
    input logic [31:0] cap, input ste_pkg::kind_e k, input logic hs,
    input logic [SSID_W-1:0] ss, input logic ov);
    exp_s       r;
    logic [2:0] cfg;
    logic [4:0] cnt;
    logic [4:0] w;
    logic [1:0] fmt;
    logic [1:0] dss;
    logic       ats;
    logic       chk;
    logic       s1on;
    logic       subs;
    logic       bad;
    cfg = ent[ste_pkg::CFG_LO +: 3];
    cnt = ent[ste_pkg::MAX_LO +: 5];
    fmt = ent[ste_pkg::FMT_LO +: 2];
    dss = ent[ste_pkg::DSS_LO +: 2];
    w = cap[ste_pkg::CAP_SSW_LO +: 5];
    ats = (k == ste_pkg::KIND_ATS_REQ);
    chk = cap[ste_pkg::CAP_CHK] && (k == ste_pkg::KIND_TRANSL);
    s1on = cfg[2] && cfg[0];
    subs = (cnt != 0) && (w != 0);
    bad = !ent[ste_pkg::V_BIT] || (s1on && !cap[ste_pkg::CAP_S1P])
      || (cfg[2] && cfg[1] && (!cap[ste_pkg::CAP_S2P]
      || cap[ste_pkg::CAP_SEC])) || (s1on && cnt > w)
      || (s1on && subs && !cap[ste_pkg::CAP_TWO_LEVEL_CD_SUPPORT]
      && (fmt == ste_pkg::FMT_4K || fmt == ste_pkg::FMT_64K));
    r = '{ste_pkg::OUT_ABORT, ste_pkg::EV_NONE, 1'b0, cfg[1]};
    if (bad) begin
      if (ats) r.o = ste_pkg::OUT_UR;
      else if (!chk) r.e = ste_pkg::EV_BAD_ENTRY;
    end else if (!cfg[2]) begin
      if (ats) r.o = ste_pkg::OUT_UR;
    end else if (cfg == ste_pkg::CFG_BYPASS && ats) begin
      r.e = ste_pkg::EV_BAD_ATS_REQ;
    end else if (cfg == ste_pkg::CFG_BYPASS && chk) begin
      r.e = ste_pkg::EV_TRANSL_FORBIDDEN;
    end else if (!cfg[0]) begin
      if (hs) r.e = ste_pkg::EV_BAD_SUBSTREAM;
      else r.o = ste_pkg::OUT_PASS;
    end else if (hs && (!subs || 32'(ss) >= (32'h1 << cnt))) begin
      r.e = ste_pkg::EV_BAD_SUBSTREAM;
    end else if (hs && dss == ste_pkg::DSS_SS0 && ss == '0) begin
      r.e = ste_pkg::EV_STREAM_DISABLED;
    end else if (hs || !subs || dss == ste_pkg::DSS_SS0) begin
      r.o = ste_pkg::OUT_PASS;
      r.s1 = 1'b1;
    end else if (dss == ste_pkg::DSS_BYP) begin
      if (ov) r.e = ste_pkg::EV_S1_ADDR_SIZE;
      else r.o = ste_pkg::OUT_PASS;
    end else if (!ats) begin
      r.e = ste_pkg::EV_STREAM_DISABLED;
    end
    return r;
  endfunction

  // one transaction, answer looked at in its single valid cycle
  task automatic send(input logic [95:0] ent, input logic [31:0] cap,
                      input ste_pkg::kind_e k, input logic hs,
                      input logic [SSID_W-1:0] ss, input logic ov);
    exp_s x;
    x = predict(ent, cap, k, hs, ss, ov);
    cli.issue(k, hs, ss, ov);
    @(posedge sys_clk);
    check("rsp_valid", 52'h1, 52'(rsp_valid));
    check("outcome", 52'(x.o), 52'(rsp_outcome));
    check("event", 52'(x.e), 52'(rsp_event));
    if (x.o == ste_pkg::OUT_PASS) begin
      check("stages", 52'({x.s1, x.s2}),
            52'({rsp_stage1, rsp_stage2}));
      check("cd_fetch", 52'(x.s1), 52'(rsp_cd_fetch));
    end
  endtask

  // descriptor location for a legal translating entry
  task automatic cd_case(input logic [2:0] cfg, input logic [1:0] fmt,
                         input logic [4:0] cnt, input logic [19:0] ss);
    logic [95:0] ent;
    logic [51:0] base;
    logic [51:0] want, m;
    int          lg;
    logic        two;
    ent = 96'h0;
    ent[ste_pkg::V_BIT] = 1'b1;
    ent[ste_pkg::CFG_LO +: 3] = cfg;
    ent[ste_pkg::FMT_LO +: 2] = fmt;
    ent[ste_pkg::PTR_HI:ste_pkg::PTR_LO] = PTR;
    ent[ste_pkg::MAX_LO +: 5] = cnt;
    ent[ste_pkg::DSS_LO +: 2] = ste_pkg::DSS_SS0;
    base = {PTR, 6'h00};
    two = (fmt == ste_pkg::FMT_4K) || (fmt == ste_pkg::FMT_64K);
    lg = (fmt == ste_pkg::FMT_64K) ? 10 : 6;
    m = (52'h1 << cnt) - 52'h1;
    want = two ? (base & ~(m >> (lg - 3))) | (52'(ss) >> lg << 3)
               : (base & ~(m << 6)) | (52'(ss) << 6);
    load(ent, ste_pkg::CAP_RST);
    send(ent, ste_pkg::CAP_RST, ste_pkg::KIND_PLAIN, ss != 0, ss, 1'b0);
    check("two_level", 52'(two), 52'(rsp_cd_two_level));
    check("cd_addr", want, rsp_cd_addr);
    check("cd_ipa", 52'(cfg[1]), 52'(rsp_cd_ipa));
    if (two) begin
      check("leaf_off", 52'(ss) % (52'h1 << lg) << 6,
            52'(rsp_leaf_off));
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [95:0] ent;
    logic [31:0] cap;
    logic [31:0] q;
    logic [31:0] ssr;
    logic        e;
    void'($urandom(32'h9b5024eb));
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // register reset values, unmapped access, write then read back
    apb(1'b0, ste_pkg::OFF_CAPS, 32'h0, q, e);
    check("caps", 52'(ste_pkg::CAP_RST), 52'(q));
    apb(1'b0, ste_pkg::OFF_WORD1, 32'h0, q, e);
    check("word1", 52'h0, 52'(q));
    apb(1'b1, 12'h020, 32'hffff_ffff, q, e);
    apb(1'b0, 12'h020, 32'h0, q, e);
    check("pslverr", 52'h1, 52'(e));
    check("unmapped", 52'h0, 52'(q));
    apb(1'b1, ste_pkg::OFF_WORD2, 32'h5a5a_0f0f, q, e);
    apb(1'b0, ste_pkg::OFF_WORD2, 32'h0, q, e);
    check("word2", 52'h5a5a_0f0f, 52'(q));
    $display("test registers done");
    cd_case(3'h5, 2'h0, 5'd4, 20'h00005);
    cd_case(3'h7, 2'h3, 5'd4, 20'h00009);
    cd_case(3'h5, 2'h0, 5'd3, 20'h00000);
    cd_case(3'h7, 2'h1, 5'd6, 20'h0002b);
    cd_case(3'h5, 2'h1, 5'd12, 20'h00e6b);
    cd_case(3'h5, 2'h2, 5'd15, 20'h05fa5);
    cd_case(3'h5, 2'h0, 5'd0, 20'h00000);
    $display("test descriptor address done");
    // random entries and capabilities, three transactions each
    for (int i = 0; i < 200; i++) begin
      cap = {22'h0, 5'($urandom % 21), 5'($urandom)};
      ent = {$urandom, $urandom, $urandom};
      ent[ste_pkg::V_BIT] = ($urandom % 8) != 0;
      ent[ste_pkg::MAX_LO +: 5] = 5'($urandom % (cap[9:5] + 2));
      load(ent, cap);
      for (int j = 0; j < 3; j++) begin
        ssr = $urandom_range(0, 32'h1 << ent[ste_pkg::MAX_LO +: 5]);
        if ($urandom % 4 == 0) ssr = 0;
        send(ent, cap, ste_pkg::kind_e'($urandom % 3), 1'($urandom),
             SSID_W'(ssr), 1'($urandom));
      end
    end
    $display("test random entries done");
    summarize();
  end
endmodule

`default_nettype wire
